// [hw/ebh_pkg.sv]
// Shared constants and types of the external bus ready/hold controller
package ebh_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int EBH_DW = 16; // External address/data width
   localparam int EBH_RW = 8; // Control register width

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] EBH_CTRL_OFS = 8'h00;
   localparam logic [7:0] EBH_ADDR_OFS = 8'h04;
   localparam logic [7:0] EBH_WDATA_OFS = 8'h08;
   localparam logic [7:0] EBH_CMD_OFS = 8'h0c;
   localparam logic [7:0] EBH_STAT_OFS = 8'h10;
   localparam logic [7:0] EBH_RDATA_OFS = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EBH_CTRL_WAIT_LSB = 0; // memory_cycle_wait_count
   localparam int EBH_CTRL_WAIT_W = 4;
   localparam int EBH_CTRL_RWDLY_BIT = 4; // Delayed strobe leading edge
   localparam int EBH_CTRL_APW_BIT = 5; // address_phase_wait (mux bus)
   localparam int EBH_CTRL_TRI_BIT = 6; // tristate_wait_option
   localparam int EBH_CTRL_HOLDEN_BIT = 7; // Accept takeover requests
   localparam int EBH_CMD_WRITE_BIT = 0;   // 1 = write cycle, 0 = read
   localparam int EBH_STAT_BUSY_BIT = 0;
   localparam int EBH_STAT_GRANT_BIT = 1;
   localparam int EBH_STAT_REGAIN_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [EBH_RW-1:0] EBH_CTRL_RST = 8'h90;
   localparam logic [EBH_DW-1:0] EBH_WORD_RST = 16'h0000;
   localparam logic [EBH_CTRL_WAIT_W-1:0] EBH_CNT_RST = 4'h0;

   // ----------------------------------------------------------------
   // Link-side sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      EBH_ST_IDLE = 8'h01,
      EBH_ST_ADDR = 8'h02,
      EBH_ST_CMD = 8'h04,
      EBH_ST_MUXW = 8'h08,
      EBH_ST_TRIW = 8'h10,
      EBH_ST_FLOAT = 8'h20,
      EBH_ST_HELD = 8'h40,
      EBH_ST_REGAIN = 8'h80
   } ebh_state_t;

endpackage

// [hw/ebh_sync2.sv]
// Two flip-flop level synchroniser with a chosen reset value
`timescale 1ns/100ps
module ebh_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RV = '0
)
(
   // Clocking
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_ff <= RV;
         q_ff <= RV;
      end
      else if (ce_i)
      begin
         meta_ff <= d_i;
         q_ff <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule

// [hw/ebh_evt_xfer.sv]
// Toggle-based single-pulse transfer between two clock domains
`timescale 1ns/100ps
module ebh_evt_xfer
(
   // Source domain
   input wire logic src_clk_i,
   input wire logic src_rst_i,
   input wire logic src_ce_i,
   input wire logic src_pulse_i,
   // Destination domain
   input wire logic dst_clk_i,
   input wire logic dst_rst_i,
   input wire logic dst_ce_i,
   output logic dst_pulse_o
);

   logic tgl_ff;
   logic meta_ff;
   logic sync_ff;
   logic last_ff;
   logic pulse_ff;

   // Source: each event flips the level; events must be spaced apart
   always_ff @(posedge src_clk_i)
   begin
      if (src_rst_i)
         tgl_ff <= 1'b0;
      else if (src_ce_i && src_pulse_i)
         tgl_ff <= ~tgl_ff;
   end

   // Destination: synchronise, then detect a change
   always_ff @(posedge dst_clk_i)
   begin
      if (dst_rst_i)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
         pulse_ff <= 1'b0;
      end
      else if (dst_ce_i)
      begin
         meta_ff <= tgl_ff;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         pulse_ff <= sync_ff ^ last_ff;
      end
   end

   assign dst_pulse_o = pulse_ff;

endmodule

// [hw/ebh_bus_ctrl.sv]
// External bus cycle sequencer with ready wait states and hold arbitration
`timescale 1ns/100ps
// Behaviour
// - At the ready sample a high ready adds a wait, a low one ends it.
// - Programmed wait states run before ready is first sampled.
// - The strobe leading edge is delayed if strobe delay is set.
// - Mux cycles get an address-phase wait, plus an optional tristate.
// - The gap is two clock output cycles for mux+tristate, one for either alone, else none.
// - A takeover is granted only after the running cycle ends.
// - Regain is requested only after the bus is floated and granted.
// - Taking the bus back starts only when the takeover request rises.
// - A request dropped without regain is taken back the same way.
module ebh_bus_ctrl
(
   // Core clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Link clock
   input wire logic clk_lnk_i,
   // External bus pins
   output logic system_clock_output_o,
   output logic [ebh_pkg::EBH_DW-1:0] ext_addr_o,
   input wire logic [ebh_pkg::EBH_DW-1:0] ext_ad_i,
   output logic [ebh_pkg::EBH_DW-1:0] ext_ad_o,
   output logic ext_ad_oe_n_o,
   output logic ext_addr_latch_o,
   output logic ext_rd_n_o,
   output logic ext_wr_n_o,
   output logic ext_ctl_oe_n_o,
   input wire logic ext_ready_n_i,
   // Arbitration pins
   input wire logic takeover_req_n_i,
   output logic takeover_grant_n_o,
   output logic bus_regain_request_n_o
);
   import ebh_pkg::*;

   // ----------------------------------------------------------------
   // Core domain: register file
   // ----------------------------------------------------------------
   logic [EBH_RW-1:0] ctrl_ff;
   logic [EBH_DW-1:0] addr_ff;
   logic [EBH_DW-1:0] wdata_ff;
   logic [EBH_DW-1:0] rdata_ff;
   logic dir_ff;
   logic busy_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic acc;
   logic wr_acc;
   logic start_req;
   logic done_core;
   logic [1:0] arb_core;
   logic [31:0] rd_word;
   logic [EBH_DW-1:0] rdw_ff;

   // Take once; ack one cycle later
   assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_acc = acc && wb_we_i;
   // Commands while busy are dropped
   assign start_req = wr_acc && (wb_adr_i == EBH_CMD_OFS) && wb_sel_i[0] &&
                      !busy_ff;

   // Bus handshake and registered read data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end
      else if (ce_i)
      begin
         ack_ff <= acc;
         if (acc && !wb_we_i)
            dat_ff <= rd_word;
      end
   end

   // Read decode; unmapped offsets read as zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (wb_adr_i == EBH_CTRL_OFS)
         rd_word[EBH_RW-1:0] = ctrl_ff;
      else if (wb_adr_i == EBH_ADDR_OFS)
         rd_word[EBH_DW-1:0] = addr_ff;
      else if (wb_adr_i == EBH_WDATA_OFS)
         rd_word[EBH_DW-1:0] = wdata_ff;
      else if (wb_adr_i == EBH_CMD_OFS)
         rd_word[EBH_CMD_WRITE_BIT] = dir_ff;
      else if (wb_adr_i == EBH_STAT_OFS)
      begin
         rd_word[EBH_STAT_BUSY_BIT] = busy_ff;
         rd_word[EBH_STAT_GRANT_BIT] = arb_core[0];
         rd_word[EBH_STAT_REGAIN_BIT] = arb_core[1];
      end
      else if (wb_adr_i == EBH_RDATA_OFS)
         rd_word[EBH_DW-1:0] = rdata_ff;
   end

   // Writable registers, frozen while busy: the link side reads them
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_ff <= EBH_CTRL_RST;
         addr_ff <= EBH_WORD_RST;
         wdata_ff <= EBH_WORD_RST;
         dir_ff <= 1'b0;
      end
      else if (ce_i && wr_acc && !busy_ff)
      begin
         if (wb_adr_i == EBH_CTRL_OFS)
         begin
            if (wb_sel_i[0])
               ctrl_ff <= wb_dat_i[EBH_RW-1:0];
         end
         else if (wb_adr_i == EBH_ADDR_OFS)
         begin
            if (wb_sel_i[0])
               addr_ff[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               addr_ff[15:8] <= wb_dat_i[15:8];
         end
         else if (wb_adr_i == EBH_WDATA_OFS)
         begin
            if (wb_sel_i[0])
               wdata_ff[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               wdata_ff[15:8] <= wb_dat_i[15:8];
         end
         else if (wb_adr_i == EBH_CMD_OFS)
         begin
            if (wb_sel_i[0])
               dir_ff <= wb_dat_i[EBH_CMD_WRITE_BIT];
         end
      end
   end

   // Busy flag and read word, stable at done
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_ff <= 1'b0;
         rdata_ff <= EBH_WORD_RST;
      end
      else if (ce_i)
      begin
         if (start_req)
            busy_ff <= 1'b1;
         else if (done_core)
         begin
            busy_ff <= 1'b0;
            rdata_ff <= rdw_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // Domain crossings
   // ----------------------------------------------------------------
   logic rst_lnk;
   logic ce_lnk;
   logic start_lnk;
   logic done_ff;
   logic [EBH_RW-1:0] ctrl_lnk;
   logic rdy_n_s;
   logic hold_n_s;
   logic [EBH_DW-1:0] ad_s;
   logic grant_n_ff;
   logic regain_n_ff;

   // Reset and enable as synchronised levels
   ebh_sync2 #(.W(1), .RV(1'b1)) u_rst_sync (.clk_i(clk_lnk_i),
      .rst_i(1'b0), .ce_i(1'b1), .d_i(rst_i), .q_o(rst_lnk));
   ebh_sync2 #(.W(1), .RV(1'b0)) u_ce_sync (.clk_i(clk_lnk_i),
      .rst_i(rst_lnk), .ce_i(1'b1), .d_i(ce_i), .q_o(ce_lnk));
   // Control only changes while idle
   ebh_sync2 #(.W(EBH_RW), .RV(EBH_CTRL_RST)) u_ctrl_sync (
      .clk_i(clk_lnk_i), .rst_i(rst_lnk), .ce_i(ce_lnk),
      .d_i(ctrl_ff), .q_o(ctrl_lnk));
   // Pin inputs, inactive levels at reset
   ebh_sync2 #(.W(1), .RV(1'b1)) u_rdy_sync (.clk_i(clk_lnk_i),
      .rst_i(rst_lnk), .ce_i(ce_lnk), .d_i(ext_ready_n_i),
      .q_o(rdy_n_s));
   ebh_sync2 #(.W(1), .RV(1'b1)) u_hold_sync (.clk_i(clk_lnk_i),
      .rst_i(rst_lnk), .ce_i(ce_lnk), .d_i(takeover_req_n_i),
      .q_o(hold_n_s));
   ebh_sync2 #(.W(EBH_DW), .RV(EBH_WORD_RST)) u_ad_sync (
      .clk_i(clk_lnk_i), .rst_i(rst_lnk), .ce_i(ce_lnk),
      .d_i(ext_ad_i), .q_o(ad_s));
   // Arbitration state back to the core
   ebh_sync2 #(.W(2), .RV(2'b00)) u_arb_sync (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(ce_i), .d_i({~regain_n_ff, ~grant_n_ff}),
      .q_o(arb_core));
   // Start and done events
   ebh_evt_xfer u_start_xfer (.src_clk_i(clk_i), .src_rst_i(rst_i),
      .src_ce_i(ce_i), .src_pulse_i(start_req), .dst_clk_i(clk_lnk_i),
      .dst_rst_i(rst_lnk), .dst_ce_i(ce_lnk), .dst_pulse_o(start_lnk));
   ebh_evt_xfer u_done_xfer (.src_clk_i(clk_lnk_i), .src_rst_i(rst_lnk),
      .src_ce_i(ce_lnk), .src_pulse_i(done_ff), .dst_clk_i(clk_i),
      .dst_rst_i(rst_i), .dst_ce_i(ce_i), .dst_pulse_o(done_core));

   // ----------------------------------------------------------------
   // Link domain: clock output and sequencer
   // ----------------------------------------------------------------
   ebh_state_t st_ff;
   logic system_clock_output_ff;
   logic pend_ff;
   logic tick;
   logic [EBH_CTRL_WAIT_W-1:0] cnt_ff;
   logic ale_ff;
   logic rd_n_ff;
   logic wr_n_ff;
   logic ctl_oe_n_ff;
   logic [EBH_DW-1:0] ad_ff;
   logic ad_oe_n_ff;
   logic [EBH_DW-1:0] a_ff;

   // Clock output is link clock / 2; the sequencer steps as it rises
   assign tick = !system_clock_output_ff;

   always_ff @(posedge clk_lnk_i)
   begin
      if (rst_lnk)
         system_clock_output_ff <= 1'b0;
      else if (ce_lnk)
         system_clock_output_ff <= ~system_clock_output_ff;
   end

   // Pending start; set wins over the clear in the same edge
   always_ff @(posedge clk_lnk_i)
   begin
      if (rst_lnk)
         pend_ff <= 1'b0;
      else if (ce_lnk)
      begin
         if (start_lnk)
            pend_ff <= 1'b1;
         else if (tick && st_ff == EBH_ST_IDLE &&
                  (hold_n_s || !ctrl_lnk[EBH_CTRL_HOLDEN_BIT]))
            pend_ff <= 1'b0;
      end
   end

   // Sequencer with its registered pins
   always_ff @(posedge clk_lnk_i)
   begin
      if (rst_lnk)
      begin
         st_ff <= EBH_ST_IDLE;
         cnt_ff <= EBH_CNT_RST;
         ale_ff <= 1'b0;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         ctl_oe_n_ff <= 1'b0;
         ad_ff <= EBH_WORD_RST;
         ad_oe_n_ff <= 1'b1;
         a_ff <= EBH_WORD_RST;
         grant_n_ff <= 1'b1;
         regain_n_ff <= 1'b1;
         rdw_ff <= EBH_WORD_RST;
         done_ff <= 1'b0;
      end
      else if (ce_lnk)
      begin
         done_ff <= 1'b0;
         if (!tick)
         begin
            // Half-cycle edge: delayed strobe leading edge
            if (st_ff == EBH_ST_CMD && rd_n_ff && wr_n_ff)
            begin
               rd_n_ff <= dir_ff;
               wr_n_ff <= !dir_ff;
            end
         end
         else
         begin
            case (st_ff)
               EBH_ST_IDLE:
               begin
                  // Only reached between cycles, so a running one ends first
                  if (!hold_n_s && ctrl_lnk[EBH_CTRL_HOLDEN_BIT])
                  begin
                     ctl_oe_n_ff <= 1'b1;
                     ad_oe_n_ff <= 1'b1;
                     st_ff <= EBH_ST_FLOAT;
                  end
                  else if (pend_ff)
                  begin
                     ale_ff <= 1'b1;
                     a_ff <= addr_ff;
                     ad_ff <= addr_ff;
                     ad_oe_n_ff <= !ctrl_lnk[EBH_CTRL_APW_BIT];
                     st_ff <= EBH_ST_ADDR;
                  end
               end
               EBH_ST_ADDR:
               begin
                  ale_ff <= 1'b0;
                  cnt_ff <= ctrl_lnk[EBH_CTRL_WAIT_LSB +: EBH_CTRL_WAIT_W];
                  ad_ff <= wdata_ff;
                  ad_oe_n_ff <= dir_ff ? 1'b0 : 1'b1;
                  // Early leading edge goes with the latch falling edge
                  if (!ctrl_lnk[EBH_CTRL_RWDLY_BIT])
                  begin
                     rd_n_ff <= dir_ff;
                     wr_n_ff <= !dir_ff;
                  end
                  st_ff <= EBH_ST_CMD;
               end
               EBH_ST_CMD:
               begin
                  if (cnt_ff != EBH_CNT_RST)
                     cnt_ff <= cnt_ff - 4'h1;
                  else if (!rdy_n_s)
                  begin
                     // Ready low ends the cycle
                     rd_n_ff <= 1'b1;
                     wr_n_ff <= 1'b1;
                     ad_oe_n_ff <= 1'b1;
                     rdw_ff <= ad_s;
                     done_ff <= 1'b1;
                     if (ctrl_lnk[EBH_CTRL_APW_BIT])
                        st_ff <= EBH_ST_MUXW;
                     else if (ctrl_lnk[EBH_CTRL_TRI_BIT])
                        st_ff <= EBH_ST_TRIW;
                     else
                        st_ff <= EBH_ST_IDLE;
                  end
                  // Ready high: stay, one more wait state
               end
               EBH_ST_MUXW:
               begin
                  if (ctrl_lnk[EBH_CTRL_TRI_BIT])
                     st_ff <= EBH_ST_TRIW;
                  else
                     st_ff <= EBH_ST_IDLE;
               end
               EBH_ST_TRIW:
                  st_ff <= EBH_ST_IDLE;
               EBH_ST_FLOAT:
               begin
                  // Bus floated one clock output cycle before the grant
                  grant_n_ff <= 1'b0;
                  st_ff <= EBH_ST_HELD;
               end
               EBH_ST_HELD:
               begin
                  // Regain asked only while the bus is handed over
                  regain_n_ff <= !pend_ff;
                  // Return of the request starts the regain, asked or not
                  if (hold_n_s)
                  begin
                     grant_n_ff <= 1'b1;
                     regain_n_ff <= 1'b1;
                     st_ff <= EBH_ST_REGAIN;
                  end
               end
               EBH_ST_REGAIN:
               begin
                  // Grant already withdrawn; drive controls again
                  ctl_oe_n_ff <= 1'b0;
                  st_ff <= EBH_ST_IDLE;
               end
               default:
                  st_ff <= EBH_ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from a flip-flop
   // ----------------------------------------------------------------
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign system_clock_output_o = system_clock_output_ff;
   assign ext_addr_o = a_ff;
   assign ext_ad_o = ad_ff;
   assign ext_ad_oe_n_o = ad_oe_n_ff;
   assign ext_addr_latch_o = ale_ff;
   assign ext_rd_n_o = rd_n_ff;
   assign ext_wr_n_o = wr_n_ff;
   assign ext_ctl_oe_n_o = ctl_oe_n_ff;
   assign takeover_grant_n_o = grant_n_ff;
   assign bus_regain_request_n_o = regain_n_ff;

endmodule

// [dv/ebh_bus_ctrl_asserts.sv]
// Pin-level concurrent checks of the external bus controller
`timescale 1ns/100ps
module ebh_bus_ctrl_chk
(
   // Core side
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Link side
   input wire logic clk_lnk_i,
   input wire logic system_clock_output_o,
   input wire logic ext_addr_latch_o,
   input wire logic ext_rd_n_o,
   input wire logic ext_wr_n_o,
   input wire logic ext_ctl_oe_n_o,
   input wire logic ext_ad_oe_n_o,
   input wire logic ext_ready_n_i,
   input wire logic takeover_req_n_i,
   input wire logic takeover_grant_n_o,
   input wire logic bus_regain_request_n_o
);
   logic [2:0] lnk_cnt_ff;
   logic lnk_off;
   // Wait out the link reset
   always_ff @(posedge clk_lnk_i)
   begin
      if (rst_i)
         lnk_cnt_ff <= 3'h0;
      else if (lnk_cnt_ff != 3'h7)
         lnk_cnt_ff <= lnk_cnt_ff + 3'h1;
   end
   assign lnk_off = rst_i | (lnk_cnt_ff != 3'h7);
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_ACK_ONE:
   assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one pulse");
   AST_SYSTEM_CLOCK_OUTPUT_TOGGLE:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      $changed(system_clock_output_o))
      else $error("clock output stuck");
   AST_FLOAT_WHILE_GRANT:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      !takeover_grant_n_o |-> ext_ctl_oe_n_o && ext_ad_oe_n_o)
      else $error("bus driven in grant");
   AST_GRANT_AFTER_CYCLE:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      $fell(takeover_grant_n_o) |->
         ext_rd_n_o && ext_wr_n_o && $past(ext_ctl_oe_n_o))
      else $error("grant inside cycle");
   AST_REGAIN_WHEN_HELD:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      !bus_regain_request_n_o |-> !takeover_grant_n_o && ext_ctl_oe_n_o)
      else $error("regain outside hold");
   AST_RELEASE_ON_REQ_HIGH:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      $rose(takeover_grant_n_o) |->
         takeover_req_n_i && $past(takeover_req_n_i, 2))
      else $error("grant dropped early");
   AST_REDRIVE_AFTER_GRANT:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      $rose(takeover_grant_n_o) |->
         ext_ctl_oe_n_o [*2] ##[1:2] !ext_ctl_oe_n_o)
      else $error("bus not redriven");
   AST_END_ON_READY:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      $rose(ext_rd_n_o) || $rose(ext_wr_n_o) |-> !$past(ext_ready_n_i, 3))
      else $error("strobe ended early");
   AST_LATCH_NO_STROBE:
   assert property (@(posedge clk_lnk_i) disable iff (lnk_off)
      ext_addr_latch_o |-> ext_rd_n_o && ext_wr_n_o)
      else $error("strobe in address phase");
   // Main scenarios reached
   COV_GRANT: cover property (@(posedge clk_lnk_i) $fell(takeover_grant_n_o));
   COV_REGAIN: cover property (@(posedge clk_lnk_i)
      $fell(bus_regain_request_n_o));
   COV_WRITE: cover property (@(posedge clk_lnk_i) $fell(ext_wr_n_o));
endmodule

// [dv/ebh_ext_model.sv]
// Far side model: ready-driving slave and an external bus master
`timescale 1ns/100ps
module ebh_ext_model
(
   // Bus pins
   input wire logic clk_lnk_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic latch_i,
   input wire logic [ebh_pkg::EBH_DW-1:0] ad_i,
   input wire logic [ebh_pkg::EBH_DW-1:0] addr_i,
   output logic ready_n_o,
   output logic [ebh_pkg::EBH_DW-1:0] ad_o,
   output logic hold_n_o,
   // Bench control and results
   input wire logic hold_i,
   input wire logic [7:0] dly_i,
   input wire logic [ebh_pkg::EBH_DW-1:0] rdat_i,
   output logic [ebh_pkg::EBH_DW-1:0] wdat_o,
   output logic [ebh_pkg::EBH_DW-1:0] addr_o
);
   import ebh_pkg::*;
   logic [7:0] cnt;
   initial
   begin
      cnt = 8'h00;
      ready_n_o = 1'b1;
      ad_o = 16'h0000;
   end
   // Ready comes dly_i link clocks into the strobe
   always @(posedge clk_lnk_i)
   begin
      cnt <= (rd_n_i && wr_n_i) ? 8'h00 : cnt + 8'h01;
      ready_n_o <= (rd_n_i && wr_n_i) || (cnt < dly_i);
   end
   // No keeper: off-strobe the slave side shows a changing pattern
   always @(posedge clk_lnk_i)
      ad_o <= !rd_n_i ? rdat_i : ~ad_o;
   // Record what the device put on the bus
   always @(posedge clk_lnk_i)
   begin
      if (latch_i)
         addr_o <= addr_i;
      if (!wr_n_i)
         wdat_o <= ad_i;
   end
   assign hold_n_o = ~hold_i;
endmodule

// [dv/tb_ext_bus_ready_hold_arbiter.sv]
// Self-checking bench of the external bus ready/hold controller
`timescale 1ns/100ps
module tb_ext_bus_ready_hold_arbiter;
   import ebh_pkg::*;
   logic clk_i, clk_lnk_i, rst_i, cyc, stb, we, ack, hold;
   logic clko, latch, rd_n, wr_n, ctl_oe_n, ad_oe_n, rdy_n, req_n;
   logic grant_n, regain_n;
   logic [7:0] adr, dly;
   logic [3:0] pins;
   logic [31:0] wdat, rdat, q;
   logic [15:0] addr, ad_out, ad_wire, m_ad, m_wdat, m_addr, m_rdat;
   int mismatches, num_checks, slo, gap, d0, d1, d2;
   // ---------------------------------------------------------------
   // Clocks, device, far side
   // ---------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Offset so link and core edges never meet
   initial
   begin
      clk_lnk_i = 1'b0;
      #7;
      forever #32 clk_lnk_i = ~clk_lnk_i;
   end
   assign ad_wire = ad_oe_n ? m_ad : ad_out;
   assign pins = {ctl_oe_n, regain_n, grant_n, rd_n};
   ebh_bus_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .clk_lnk_i(clk_lnk_i), .system_clock_output_o(clko),
      .ext_addr_o(addr), .ext_ad_i(ad_wire), .ext_ad_o(ad_out),
      .ext_ad_oe_n_o(ad_oe_n), .ext_addr_latch_o(latch),
      .ext_rd_n_o(rd_n), .ext_wr_n_o(wr_n), .ext_ctl_oe_n_o(ctl_oe_n),
      .ext_ready_n_i(rdy_n), .takeover_req_n_i(req_n),
      .takeover_grant_n_o(grant_n), .bus_regain_request_n_o(regain_n));
   ebh_ext_model ext_u (.clk_lnk_i(clk_lnk_i), .rd_n_i(rd_n),
      .wr_n_i(wr_n), .latch_i(latch), .ad_i(ad_wire), .addr_i(addr),
      .ready_n_o(rdy_n), .ad_o(m_ad), .hold_n_o(req_n), .hold_i(hold),
      .dly_i(dly), .rdat_i(m_rdat), .wdat_o(m_wdat), .addr_o(m_addr));
   // Strobe-low length in link clocks
   always @(posedge clk_lnk_i)
      slo <= slo + ((!rd_n || !wr_n) ? 1 : 0);
   // Driven idle link clocks since the last strobe rose
   always @(posedge clk_lnk_i)
      gap <= (!rd_n || !wr_n) ? 0 : gap + (ctl_oe_n ? 0 : 1);
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic single cycle; the result lands in q
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 40);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      if (n >= 40)
      begin
         chk({31'h0, ack}, 32'h1);
         tally_and_finish();
      end
   endtask
   task wait_pin(input int i, input logic v);
      int n;
      n = 0;
      while (pins[i] !== v && n < 400)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400)
      begin
         chk({31'h0, pins[i]}, {31'h0, v});
         tally_and_finish();
      end
   endtask
   task wait_idle;
      int n;
      n = 0;
      do
      begin
         wb(1'b0, EBH_STAT_OFS, 32'h0);
         n++;
      end
      while (q[EBH_STAT_BUSY_BIT] !== 1'b0 && n < 300);
      if (n >= 300)
      begin
         chk(q, 32'h0);
         tally_and_finish();
      end
   endtask
   // One external cycle; d is its strobe-low length
   task run(input logic w, output int d);
      slo = 0;
      wb(1'b1, EBH_CMD_OFS, {31'h0, w});
      wait_idle();
      d = slo;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      {rst_i, cyc, stb, we, hold, adr, wdat, dly} = {5'h10, 8'h0, 32'h0, 8'h0};
      {mismatches, num_checks, slo, gap, m_rdat} = {128'h0, 16'h3c5a};
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, EBH_CTRL_OFS, 32'h0);
      chk(q, {24'h0, EBH_CTRL_RST});
      wb(1'b1, 8'h1c, 32'hffff);
      wb(1'b0, 8'h1c, 32'h0);
      chk(q, 32'h0);
      chk({28'h0, pins}, 32'h7);
      $display("test reset values done");
      wb(1'b1, EBH_CTRL_OFS, 32'h80);
      wb(1'b1, EBH_ADDR_OFS, 32'h1234);
      wb(1'b1, EBH_WDATA_OFS, 32'ha5c3);
      run(1'b1, d0);
      chk({m_addr, m_wdat}, 32'h1234a5c3);
      run(1'b0, d0);
      wb(1'b0, EBH_RDATA_OFS, 32'h0);
      chk(q, {16'h0, m_rdat});
      $display("test data cycles done");
      wb(1'b1, EBH_CTRL_OFS, 32'h83);
      run(1'b0, d1);
      chk(d1 - d0, 32'd4);
      wb(1'b1, EBH_CTRL_OFS, 32'h93);
      run(1'b0, d2);
      chk(d1 - d2, 32'd1);
      wb(1'b1, EBH_CTRL_OFS, 32'h80);
      dly = 8'd9;
      run(1'b0, d1);
      chk({31'h0, (d1 - d0 == 8) || (d1 - d0 == 10)}, 32'h1);
      $display("test wait states done");
      wb(1'b1, EBH_CTRL_OFS, 32'he0);
      dly = 8'd20;
      wb(1'b1, EBH_CMD_OFS, 32'h0);
      wait_pin(0, 1'b0);
      hold <= 1'b1;
      wait_pin(1, 1'b0);
      chk({31'h0, rd_n}, 32'h1);
      chk(gap, 32'd6);
      repeat (8) @(posedge clk_i);
      wb(1'b0, EBH_STAT_OFS, 32'h0);
      chk(q & 32'h7, 32'h2);
      m_rdat = 16'hc3a5;
      wb(1'b1, EBH_CMD_OFS, 32'h0);
      wait_pin(2, 1'b0);
      repeat (40) @(posedge clk_i);
      chk({30'h0, grant_n, rd_n}, 32'h1);
      hold <= 1'b0;
      wait_pin(1, 1'b1);
      wait_idle();
      wb(1'b0, EBH_RDATA_OFS, 32'h0);
      chk(q, 32'hc3a5);
      $display("test hold with regain done");
      dly = 8'd0;
      hold <= 1'b1;
      wait_pin(1, 1'b0);
      repeat (10) @(posedge clk_i);
      chk({31'h0, regain_n}, 32'h1);
      hold <= 1'b0;
      wait_pin(1, 1'b1);
      wait_pin(3, 1'b0);
      wb(1'b1, EBH_WDATA_OFS, 32'h5a3c);
      run(1'b1, d0);
      chk({16'h0, m_wdat}, 32'h5a3c);
      $display("test unrequested release done");
      tally_and_finish();
   end
endmodule
bind ebh_bus_ctrl ebh_bus_ctrl_chk chk_u (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .clk_lnk_i, .system_clock_output_o,
   .ext_addr_latch_o, .ext_rd_n_o, .ext_wr_n_o, .ext_ctl_oe_n_o,
   .ext_ad_oe_n_o, .ext_ready_n_i, .takeover_req_n_i, .takeover_grant_n_o,
   .bus_regain_request_n_o);
